// >>> inc/tfs_map.vh
// Register offsets, field positions and mode codes for the
// trigger flow sequencer. Assumes inclusion by bare name from design files.
`ifndef TFS_MAP_VH
`define TFS_MAP_VH

// ************************************************************
// Register byte offsets
// ************************************************************
`define TFS_CTRL_OFS       12'h000
`define TFS_STATUS_OFS     12'h004
`define TFS_STATE_OFS      12'h008
`define TFS_FLAGS_OFS      12'h00C
`define TFS_QUOTA_OFS      12'h010
`define TFS_SEGCNT_OFS     12'h014
`define TFS_EXTCFG_OFS     12'h018
`define TFS_PROG_ADDR_OFS  12'h01C
`define TFS_PROG_DATA_OFS  12'h020
`define TFS_CINIT_OFS      12'h024
`define TFS_FINIT_OFS      12'h028
`define TFS_CNT_BASE_OFS   12'h100

// ************************************************************
// Control register fields
// ************************************************************
`define TFS_CTRL_START     0
`define TFS_CTRL_STOP      1
`define TFS_CTRL_SEGMENTED 2
`define TFS_CTRL_QUAL      3

// ************************************************************
// Branch word fields (64-bit entry in the branch table)
// ************************************************************
`define TFS_BR_VALID       63
`define TFS_BR_HEADER      62
`define TFS_BR_TERM_HI     61
`define TFS_BR_TERM_LO     54
`define TFS_BR_TSEL_HI     53
`define TFS_BR_TSEL_LO     49
`define TFS_BR_OP_HI       48
`define TFS_BR_OP_LO       46
`define TFS_BR_KIND        45
`define TFS_BR_CONST_HI    44
`define TFS_BR_CONST_LO    29
`define TFS_BR_RSEL_HI     28
`define TFS_BR_RSEL_LO     24
`define TFS_BR_RACT_HI     23
`define TFS_BR_RACT_LO     21
`define TFS_BR_BUF_HI      20
`define TFS_BR_BUF_LO      18
`define TFS_BR_JUMP        17
`define TFS_BR_DEST_HI     16
`define TFS_BR_DEST_LO     12
`define TFS_BR_COMB_HI     11
`define TFS_BR_COMB_LO     0

// ************************************************************
// Action codes
// ************************************************************
`define TFS_RACT_NONE      3'h0
`define TFS_RACT_INC       3'h1
`define TFS_RACT_DEC       3'h2
`define TFS_RACT_RST       3'h3
`define TFS_RACT_SET       3'h4
`define TFS_RACT_CLR       3'h5
`define TFS_BUF_NONE       3'h0
`define TFS_BUF_FINAL      3'h1
`define TFS_BUF_SLICE      3'h2
`define TFS_BUF_BEGIN      3'h3
`define TFS_BUF_HALT       3'h4

// ************************************************************
// Comparator codes
// ************************************************************
`define TFS_OP_GT          3'h0
`define TFS_OP_GE          3'h1
`define TFS_OP_EQ          3'h2
`define TFS_OP_NE          3'h3
`define TFS_OP_LE          3'h4
`define TFS_OP_LT          3'h5

`endif

// >>> design/tfs_cond_eval.v
// Condition evaluator for one branch of the trigger flow sequencer.
// Assumes a purely combinational use by the sequencer core.
`timescale 1ns/1ns
`include "tfs_map.vh"

module tfs_cond_eval #(
   parameter NCOND = 8,
   parameter NRES  = 20,
   parameter CW    = 16
) (
   input  wire [63:0]      branch,
   input  wire [NCOND-1:0] cond_in,
   input  wire [NRES*CW-1:0] cnt_flat,
   input  wire [NRES-1:0]  flag_vec,
   output reg              hit
);

   reg [7:0]  term;
   reg [4:0]  tsel;
   reg [2:0]  op;
   reg [15:0] k;
   reg [CW-1:0] opnd;
   reg        rel;
   reg [11:0] comb;
   reg        a;
   reg        b;
   reg        t1;
   reg        t2;

   // Selector: bit 3 enables, bits 2:0 pick a condition input; else one
   function pick;
      input [3:0]       f_s;
      input [NCOND-1:0] f_c;
      begin
         if (f_s[3] && f_s[2:0] < NCOND)
            pick = f_c[f_s[2:0]];
         else
            pick = 1'b1;
      end
   endfunction

   function cmp;
      input [2:0]    f_op;
      input [CW-1:0] f_v;
      input [CW-1:0] f_k;
      begin
         case (f_op)
            `TFS_OP_GT: cmp = f_v >  f_k;
            `TFS_OP_GE: cmp = f_v >= f_k;
            `TFS_OP_EQ: cmp = f_v == f_k;
            `TFS_OP_NE: cmp = f_v != f_k;
            `TFS_OP_LE: cmp = f_v <= f_k;
            `TFS_OP_LT: cmp = f_v <  f_k;
            default:    cmp = 1'b0;
         endcase
      end
   endfunction

   // Fixed tree: (rel op t1) op (t2 op one), every term and group
   // invertible; all-zero fields leave the bare comparator result
   always @* begin
      term = branch[`TFS_BR_TERM_HI:`TFS_BR_TERM_LO];
      tsel = branch[`TFS_BR_TSEL_HI:`TFS_BR_TSEL_LO];
      op   = branch[`TFS_BR_OP_HI:`TFS_BR_OP_LO];
      k    = branch[`TFS_BR_CONST_HI:`TFS_BR_CONST_LO];
      comb = branch[`TFS_BR_COMB_HI:`TFS_BR_COMB_LO];
      opnd = {CW{1'b0}};
      if (tsel < NRES) begin
         if (branch[`TFS_BR_KIND])
            opnd = {{(CW-1){1'b0}}, flag_vec[tsel]};
         else
            opnd = cnt_flat[tsel*CW +: CW];
      end
      rel = cmp(op, opnd, k[CW-1:0]);
      t1 = pick(term[3:0], cond_in);
      t2 = pick(term[7:4], cond_in);
      a = rel ^ comb[0];
      a = comb[8] ? (a | (t1 ^ comb[1]))
                  : (a & (t1 ^ comb[1]));
      a = a ^ comb[4];
      b = t2 ^ comb[2];
      b = comb[9] ? (b | ~comb[3])
                  : (b & ~comb[3]);
      b = b ^ comb[5];
      hit = comb[10] ? (a | b) : (a & b);
      hit = (hit ^ comb[11]) & branch[`TFS_BR_VALID];
   end

endmodule

// >>> design/tfs_top.v
// Trigger flow sequencer: programmable state machine with APB registers.
// Assumes condition inputs are synchronous to pclk.
`timescale 1ns/1ns
`include "tfs_map.vh"

module tfs_top #(
   parameter NCOND  = 8,
   parameter NRES   = 20,
   parameter CW     = 16,
   parameter NSTATE = 20,
   parameter NBR    = 64,
   parameter BRW    = 6
) (
   input  wire             pclk,
   input  wire             presetn,
   input  wire             psel,
   input  wire             penable,
   input  wire             pwrite,
   input  wire [11:0]      paddr,
   input  wire [31:0]      pwdata,
   output reg  [31:0]      prdata,
   output reg              pready,
   output reg              pslverr,
   input  wire [NCOND-1:0] cond_in,
   input  wire             ext_trig_in,
   output reg              buffer_write_gate,
   output reg              segment_close,
   output reg              acq_done
);

   // ************************************************************
   // Storage
   // ************************************************************
   reg [63:0]      br_mem [0:NBR-1];
   reg [4:0]       br_state [0:NBR-1];
   reg [CW-1:0]    cnt_reg [0:NRES-1];
   reg [CW-1:0]    cinit_reg [0:NRES-1];
   reg [NRES-1:0]  flag_reg;
   reg [NRES-1:0]  finit_reg;
   reg [4:0]       state_reg;
   reg [3:0]       ctrl_reg;
   reg [15:0]      quota_reg;
   reg [15:0]      segcnt_reg;
   reg [1:0]       extcfg_reg;
   reg [BRW-1:0]   paddr_ptr_reg;
   reg [31:0]      pdata_lo_reg;
   reg             run_reg;
   reg             ext_seen_reg;
   reg             final_reg;
   reg             gate_reg;
   reg [15:0]      post_reg;
   reg [15:0]      seg_post_reg;
   reg             seg_arm_reg;
   reg [15:0]      seg_idx_reg;

   localparam [1:0] ST_IDLE = 2'b01;
   localparam [1:0] ST_RUN  = 2'b10;
   reg [1:0] fsm_reg;

   integer i;
   integer j;

   // ************************************************************
   // Branch scan: pick first hit inside current state
   // ************************************************************
   wire [NRES*CW-1:0] cnt_flat;
   wire [NBR-1:0]     hit_vec;
   genvar g;
   generate
      for (g = 0; g < NRES; g = g + 1) begin : g_flat
         assign cnt_flat[g*CW +: CW] = cnt_reg[g];
      end
      for (g = 0; g < NBR; g = g + 1) begin : g_eval
         wire h;
         tfs_cond_eval #(
            .NCOND (NCOND),
            .NRES  (NRES),
            .CW    (CW)
         ) u_eval (
            .branch   (br_mem[g]),
            .cond_in  (cond_in),
            .cnt_flat (cnt_flat),
            .flag_vec (flag_reg),
            .hit      (h)
         );
         // Owner state recorded at load; a branch hits only in its owner state
         assign hit_vec[g] = h && (br_state[g] == state_reg);
      end
   endgenerate

   reg [63:0] win_br;
   reg        win;
   always @* begin
      win    = 1'b0;
      win_br = 64'h0000_0000_0000_0000;
      for (j = NBR - 1; j >= 0; j = j - 1) begin
         if (hit_vec[j]) begin
            win    = 1'b1;
            win_br = br_mem[j];
         end
      end
   end

   wire [4:0]  w_rsel = win_br[`TFS_BR_RSEL_HI:`TFS_BR_RSEL_LO];
   wire [2:0]  w_ract = win_br[`TFS_BR_RACT_HI:`TFS_BR_RACT_LO];
   wire [2:0]  w_buf  = win_br[`TFS_BR_BUF_HI:`TFS_BR_BUF_LO];
   wire [15:0] w_k    = win_br[`TFS_BR_CONST_HI:`TFS_BR_CONST_LO];
   wire        seg_md = ctrl_reg[`TFS_CTRL_SEGMENTED];
   wire        qual   = ctrl_reg[`TFS_CTRL_QUAL] & ~seg_md;
   wire        ext_ok = ~extcfg_reg[0] | ext_seen_reg | ext_trig_in;
   wire        act    = (fsm_reg == ST_RUN) & win & ext_ok;
   wire        wr_now = qual ? gate_reg : 1'b1;

   // ************************************************************
   // APB slave, zero wait states
   // ************************************************************
   wire apb_wr = psel & penable & pwrite;
   wire apb_rd = psel & ~penable & ~pwrite;
   wire cnt_hit = (paddr >= `TFS_CNT_BASE_OFS) &&
                  (paddr < `TFS_CNT_BASE_OFS + 12'd80);
   wire [4:0] cidx = paddr[6:2] - 5'd0;
   wire known = cnt_hit || (paddr <= `TFS_FINIT_OFS && paddr[1:0] == 2'b00);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~known;
         if (apb_rd) begin
            prdata <= 32'h0000_0000;
            case (paddr)
               `TFS_CTRL_OFS:   prdata <= {28'h000_0000, ctrl_reg};
               `TFS_STATUS_OFS: prdata <= {26'h000_0000, acq_done,
                                           final_reg, gate_reg,
                                           ext_seen_reg, run_reg,
                                           seg_md};
               `TFS_STATE_OFS:  prdata <= {27'h000_0000, state_reg};
               `TFS_FLAGS_OFS:  prdata <= {{(32-NRES){1'b0}}, flag_reg};
               `TFS_QUOTA_OFS:  prdata <= {16'h0000, quota_reg};
               `TFS_SEGCNT_OFS: prdata <= {seg_idx_reg, segcnt_reg};
               `TFS_EXTCFG_OFS: prdata <= {30'h0000_0000, extcfg_reg};
               `TFS_FINIT_OFS:  prdata <= {{(32-NRES){1'b0}}, finit_reg};
               default: begin
                  if (cnt_hit && cidx < NRES)
                     prdata <= {{(32-CW){1'b0}}, cnt_reg[cidx]};
               end
            endcase
         end
      end
   end

   // ************************************************************
   // Configuration registers
   // ************************************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg      <= 4'h0;
         quota_reg     <= 16'h0000;
         segcnt_reg    <= 16'h0004;
         extcfg_reg    <= 2'b00;
         paddr_ptr_reg <= {BRW{1'b0}};
         pdata_lo_reg  <= 32'h0000_0000;
         finit_reg     <= {NRES{1'b0}};
      end else begin
         ctrl_reg[`TFS_CTRL_START] <= 1'b0;
         ctrl_reg[`TFS_CTRL_STOP]  <= 1'b0;
         if (apb_wr) begin
            case (paddr)
               `TFS_CTRL_OFS:      ctrl_reg <= pwdata[3:0];
               `TFS_QUOTA_OFS:     quota_reg <= pwdata[15:0];
               `TFS_SEGCNT_OFS:    segcnt_reg <= pwdata[15:0];
               `TFS_EXTCFG_OFS:    extcfg_reg <= pwdata[1:0];
               `TFS_PROG_ADDR_OFS: paddr_ptr_reg <= pwdata[BRW-1:0];
               `TFS_PROG_DATA_OFS: pdata_lo_reg <= pwdata;
               `TFS_FINIT_OFS:     finit_reg <= pwdata[NRES-1:0];
               default: ;
            endcase
            if (paddr == `TFS_STATE_OFS)
               paddr_ptr_reg <= paddr_ptr_reg + 1'b1;
         end
      end
   end

   // Branch table: write low word to PROG_DATA, then high word plus
   // owner state to STATE offset; pointer advances on each commit
   always @(posedge pclk) begin
      if (apb_wr && paddr == `TFS_STATE_OFS) begin
         br_mem[paddr_ptr_reg]   <= {pwdata[26:0], 5'h00, pdata_lo_reg};
         br_state[paddr_ptr_reg] <= pwdata[31:27];
      end
      if (apb_wr && paddr == `TFS_CINIT_OFS && pwdata[20:16] < NRES)
         cinit_reg[pwdata[20:16]] <= pwdata[CW-1:0];
   end

   // ************************************************************
   // Sequencer
   // ************************************************************
   wire start_p = ctrl_reg[`TFS_CTRL_START];
   wire stop_p  = ctrl_reg[`TFS_CTRL_STOP];
   wire fin_p   = act && w_buf == `TFS_BUF_FINAL;
   wire force_p = stop_p && (fsm_reg == ST_RUN);
   wire [15:0] fin_q = (w_k != 16'h0000) ? w_k : quota_reg;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fsm_reg           <= ST_IDLE;
         state_reg         <= 5'h00;
         flag_reg          <= {NRES{1'b0}};
         run_reg           <= 1'b0;
         ext_seen_reg      <= 1'b0;
         final_reg         <= 1'b0;
         gate_reg          <= 1'b0;
         post_reg          <= 16'h0000;
         seg_post_reg      <= 16'h0000;
         seg_arm_reg       <= 1'b0;
         seg_idx_reg       <= 16'h0000;
         buffer_write_gate <= 1'b0;
         segment_close     <= 1'b0;
         acq_done          <= 1'b0;
         for (i = 0; i < NRES; i = i + 1)
            cnt_reg[i] <= {CW{1'b0}};
      end else begin
         segment_close <= 1'b0;
         case (fsm_reg)
            ST_IDLE: begin
               buffer_write_gate <= 1'b0;
               if (start_p) begin
                  fsm_reg      <= ST_RUN;
                  run_reg      <= 1'b1;
                  state_reg    <= 5'h00;
                  flag_reg     <= finit_reg;
                  final_reg    <= 1'b0;
                  ext_seen_reg <= 1'b0;
                  acq_done     <= 1'b0;
                  seg_idx_reg  <= 16'h0000;
                  seg_arm_reg  <= 1'b0;
                  gate_reg     <= ~ctrl_reg[`TFS_CTRL_QUAL];
                  buffer_write_gate <= 1'b0;
                  for (i = 0; i < NRES; i = i + 1)
                     cnt_reg[i] <= cinit_reg[i];
               end
            end
            ST_RUN: begin
               if (extcfg_reg[0] && ext_trig_in)
                  ext_seen_reg <= 1'b1;
               if (act) begin
                  if (w_rsel < NRES) begin
                     case (w_ract)
                        `TFS_RACT_INC: cnt_reg[w_rsel] <=
                           cnt_reg[w_rsel] + 1'b1;
                        `TFS_RACT_DEC: cnt_reg[w_rsel] <=
                           cnt_reg[w_rsel] - 1'b1;
                        `TFS_RACT_RST: cnt_reg[w_rsel] <=
                           cinit_reg[w_rsel];
                        `TFS_RACT_SET: flag_reg[w_rsel] <= 1'b1;
                        `TFS_RACT_CLR: flag_reg[w_rsel] <= 1'b0;
                        default: ;
                     endcase
                  end
                  if (win_br[`TFS_BR_JUMP] &&
                      win_br[`TFS_BR_DEST_HI:`TFS_BR_DEST_LO] < NSTATE)
                     state_reg <=
                        win_br[`TFS_BR_DEST_HI:`TFS_BR_DEST_LO];
                  // Gating keeps working even after final trigger
                  if (qual && w_buf == `TFS_BUF_BEGIN)
                     gate_reg <= 1'b1;
                  if (qual && w_buf == `TFS_BUF_HALT)
                     gate_reg <= 1'b0;
                  if (seg_md && w_buf == `TFS_BUF_SLICE) begin
                     // A new slice cuts short any pending post-fill
                     if (seg_arm_reg)
                        segment_close <= 1'b1;
                     seg_arm_reg  <= 1'b1;
                     seg_post_reg <= fin_q;
                  end
               end
               if (seg_arm_reg && !(act && w_buf == `TFS_BUF_SLICE)) begin
                  if (seg_post_reg == 16'h0000) begin
                     segment_close <= 1'b1;
                     seg_arm_reg   <= 1'b0;
                     // Wraps onto oldest segment when all are used
                     seg_idx_reg <= (seg_idx_reg + 1'b1 >= segcnt_reg) ?
                                    16'h0000 : seg_idx_reg + 1'b1;
                  end else
                     seg_post_reg <= seg_post_reg - 1'b1;
               end
               // Stop also ends a run paused after its final trigger
               if (force_p) begin
                  final_reg <= 1'b1;
                  post_reg  <= 16'h0000;
                  gate_reg  <= 1'b1;
               end else if (fin_p && !final_reg) begin
                  final_reg <= 1'b1;
                  post_reg  <= fin_q;
               end
               if (final_reg && wr_now) begin
                  if (post_reg == 16'h0000) begin
                     fsm_reg  <= ST_IDLE;
                     run_reg  <= 1'b0;
                     acq_done <= 1'b1;
                  end else
                     post_reg <= post_reg - 1'b1;
               end
               buffer_write_gate <= wr_now &
                                    ~(final_reg && post_reg == 16'h0000);
            end
            default: fsm_reg <= ST_IDLE;
         endcase
      end
   end

endmodule

// >>> tb/tfs_chk_properties.sv
// Port checker for the trigger flow sequencer.
// Assumes binding to tfs_top, one clock, async low reset.
`timescale 1ns/1ns
module tfs_chk (
   input logic        pclk,
   input logic        presetn,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [11:0] paddr,
   input logic [31:0] pwdata,
   input logic        pready,
   input logic        pslverr,
   input logic        buffer_write_gate,
   input logic        segment_close,
   input logic        acq_done
);
   // ************************************************************
   // Mode tracking from control writes
   // ************************************************************
   logic seg_reg;
   logic st_d;
   wire  ctl_wr = psel && penable && pwrite && paddr == 12'h000;
   wire  st = ctl_wr && pwdata[0];
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seg_reg <= 1'b0;
         st_d    <= 1'b0;
      end else begin
         st_d <= st;
         if (ctl_wr)
            seg_reg <= pwdata[2];
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ************************************************************
   // Properties
   // ************************************************************
   a_ready_access: assert property (psel && penable |-> pready)
      else $error("pready missing in access phase");
   a_ready_phase: assert property (pready |-> psel && penable)
      else $error("pready outside access phase");
   a_ready_once: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_slice_pulse: assert property (segment_close |=> !segment_close)
      else $error("segment close not a pulse");
   a_slice_mode: assert property (segment_close |-> seg_reg)
      else $error("segment close outside segmented mode");
   // Start acts one cycle after the control write lands
   a_done_holds: assert property (acq_done && !st && !st_d
      |=> acq_done)
      else $error("done dropped without start");
   a_done_start: assert property (st |-> ##2 !acq_done)
      else $error("done not cleared by start");
   a_done_no_write: assert property (acq_done && !st
      |=> !buffer_write_gate)
      else $error("write after acquisition done");
   cover property (pslverr);
   cover property ($rose(acq_done));
   cover property (segment_close);
   cover property (buffer_write_gate ##1 !buffer_write_gate);
endmodule

// >>> tb/tfs_probe.sv
// Probed user logic: drives conditions and the external trigger,
// counts written samples and segment closes. Assumes one clock.
`timescale 1ns/1ns
module tfs_probe (
   input  logic        pclk,
   input  logic        presetn,
   input  logic        ext_req,
   input  logic        buffer_write_gate,
   input  logic        segment_close,
   output logic [7:0]  cond_in,
   output logic        ext_trig_in,
   output logic [15:0] gate_cnt,
   output logic [15:0] close_cnt
);
   // ************************************************************
   // Stimulus and counting
   // ************************************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cond_in     <= 8'h01;
         ext_trig_in <= 1'b0;
         gate_cnt    <= 16'h0000;
         close_cnt   <= 16'h0000;
      end else begin
         // Walking pattern so no condition line sits still
         cond_in     <= {cond_in[6:0], cond_in[7]};
         ext_trig_in <= ext_req;
         gate_cnt    <= gate_cnt + {15'h0000, buffer_write_gate};
         close_cnt   <= close_cnt + {15'h0000, segment_close};
      end
   end
endmodule

// >>> tb/tb.sv
// Testbench: APB tasks and flow scenarios for the sequencer.
// Assumes branch condition fields zero mean comparator on counter 0.
`timescale 1ns/1ns
`include "tfs_map.vh"
module tb;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        err, ext_req, ext_trig_in;
   logic        buffer_write_gate, segment_close, acq_done;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, r1;
   logic [7:0]  cond_in;
   logic [15:0] gate_cnt, close_cnt, g0, s0;
   int          error_cnt, check_count;
   localparam logic [2:0] EQ = `TFS_OP_EQ, GE = `TFS_OP_GE;
   localparam logic [2:0] INC = `TFS_RACT_INC, DEC = `TFS_RACT_DEC;
   localparam logic [2:0] RST = `TFS_RACT_RST, SET = `TFS_RACT_SET;
   localparam logic [2:0] FIN = `TFS_BUF_FINAL, SLC = `TFS_BUF_SLICE;
   localparam logic [2:0] BEG = `TFS_BUF_BEGIN, HLT = `TFS_BUF_HALT;
   localparam logic [11:0] CNT = `TFS_CNT_BASE_OFS;

   tfs_top u_tfs_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .cond_in, .ext_trig_in,
      .buffer_write_gate, .segment_close, .acq_done);
   tfs_probe u_tfs_probe (.pclk, .presetn, .ext_req, .buffer_write_gate,
      .segment_close, .cond_in, .ext_trig_in, .gate_cnt, .close_cnt);

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // ************************************************************
   // Tasks
   // ************************************************************
   task summarize;
      if (error_cnt == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 8; i++) begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      chk("pready", 1, pready);
      if (pready !== 1'b1)
         summarize;
   endtask
   task rdc(input string n, input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(n, e, rd);
   endtask
   task wait_done;
      int i;
      for (i = 0; i < 2000 && acq_done !== 1'b1; i++)
         @(posedge pclk);
      chk("acq_done", 1, acq_done);
      if (acq_done !== 1'b1)
         summarize;
   endtask
   // Branch entry: owner state, comparator on counter 0, actions
   // Entry bits 36:32 load as zero, so constants keep bits 7:3 clear
   task p(input logic [4:0] o, input logic [2:0] op, input logic [15:0] k,
      input logic [4:0] rs, input logic [2:0] ra, input logic [2:0] bf,
      input logic j, input logic [4:0] ds);
      logic [63:0] w;
      w = {2'h2, 8'h00, 5'h00, op, 1'b0, k, rs, ra, bf, j, ds, 12'h000};
      apb(1'b1, `TFS_PROG_DATA_OFS, w[31:0]);
      apb(1'b1, `TFS_STATE_OFS, {o, w[63:37]});
   endtask
   task ini(input logic [15:0] v);
      apb(1'b1, `TFS_PROG_ADDR_OFS, 32'h0000_0000);
      apb(1'b1, `TFS_CINIT_OFS, {16'h0000, v});
      apb(1'b1, `TFS_FINIT_OFS, 32'h0000_0000);
   endtask
   task run(input logic [31:0] c);
      g0 = gate_cnt;
      s0 = close_cnt;
      apb(1'b1, `TFS_CTRL_OFS, c);
   endtask
   // ************************************************************
   // Scenarios
   // ************************************************************
   initial begin
      {presetn, psel, penable, pwrite, ext_req} = 5'h00;
      paddr  = 12'h000;
      pwdata = 32'h0000_0000;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      chk("outputs", 0, {buffer_write_gate, segment_close, acq_done});
      rdc("state", `TFS_STATE_OFS, 0);
      apb(1'b0, 12'hFFC, 32'h0000_0000);
      chk("pslverr", 1, err);
      // Counter ops, priority, state scoping, jump
      ini(16'h0005);
      p(1, EQ, 16'h0007, 0, RST, FIN, 0, 0);
      p(1, EQ, 16'h0005, 0, DEC, 0, 0, 0);
      p(0, EQ, 16'h0007, 3, SET, 0, 1, 1);
      p(0, GE, 16'h0000, 0, INC, 0, 0, 0);
      run(32'h0000_0001);
      wait_done;
      rdc("counter", CNT, 32'h0000_0004);
      rdc("flags", `TFS_FLAGS_OFS, 32'h0000_0008);
      rdc("state", `TFS_STATE_OFS, 32'h0000_0001);
      // Qualified writes, halt after final, host stop
      ini(16'h0000);
      p(0, EQ, 16'h0002, 0, INC, BEG, 0, 0);
      p(0, EQ, 16'h0004, 0, INC, FIN, 0, 0);
      p(0, EQ, 16'h0006, 0, INC, HLT, 0, 0);
      p(0, GE, 16'h0000, 0, INC, 0, 0, 0);
      run(32'h0000_0009);
      repeat (40) @(posedge pclk);
      chk("paused", 0, acq_done);
      chk("written", 4, gate_cnt - g0);
      apb(1'b0, CNT, 32'h0000_0000);
      r1 = rd;
      apb(1'b0, CNT, 32'h0000_0000);
      chk("live count", 1, rd != r1);
      apb(1'b1, `TFS_CTRL_OFS, 32'h0000_000A);
      wait_done;
      // Segmented mode behind an external trigger
      ini(16'h0000);
      p(0, EQ, 16'h0003, 0, INC, SLC, 0, 0);
      p(0, EQ, 16'h0006, 0, INC, HLT, 0, 0);
      p(0, EQ, 16'h0100, 0, INC, FIN, 0, 0);
      p(0, GE, 16'h0000, 0, INC, 0, 0, 0);
      apb(1'b1, `TFS_EXTCFG_OFS, 32'h0000_0001);
      run(32'h0000_0005);
      repeat (20) @(posedge pclk);
      rdc("held", CNT, 32'h0000_0000);
      ext_req <= 1'b1;
      wait_done;
      chk("segments", 1, close_cnt != s0);
      chk("ungated", 1, gate_cnt - g0 > 16'h0014);
      summarize;
   end
endmodule
bind tfs_top tfs_chk u_tfs_chk (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pready, .pslverr, .buffer_write_gate, .segment_close,
   .acq_done);
